// ---- core/bfe_event_irq.sv ----
// Data link and code event flags, enables, interrupt and register slave
//
// Implementation choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
`include "bfe_cfg.svh"
module bfe_event_irq
   import bfe_pkg::*;
(
   input  wire logic        clock_in,
   input  wire logic        rst_n_in,
   input  wire logic [7:0]  address_in,
   input  wire logic        read_in,
   input  wire logic        write_in,
   input  wire logic [31:0] writedata_in,
   output logic      [31:0] readdata_out,
   output logic             waitrequest_out,
   input  wire logic [15:0] rx_msg_in,
   input  wire logic        rx_msg_valid_in,
   input  wire logic        rx_code_valid_in,
   input  wire logic        filter_ok_in,
   input  wire logic        rx_bit_in,
   input  wire logic        rx_bit_en_in,
   input  wire logic        tx_load_in,
   input  wire logic        tx_rep_done_in,
   input  wire logic [5:0]  ssm_in,
   input  wire logic        ssm_valid_in,
   output logic             irq_out
);

   // ***********************************************
   // Declarations
   // ***********************************************
   bfe_bus_state_t bus_state;
   logic [7:0]     status;
   logic [7:0]     enable;
   logic           ustatus;
   logic           uenable;
   logic [5:0]     match_code [3];
   logic [7:0]     repeat_count;
   logic [7:0]     tx_count;
   logic [1:0]     noncode_run;
   logic [3:0]     ones_run;
   logic [5:0]     last_code;
   logic           code_seen;
   logic [5:0]     last_ssm;
   logic           ssm_seen;
   logic [7:0]     set_bits;
   logic [7:0]     rd_value;
   logic [5:0]     rx_code;
   logic           framed;
   logic           validated;
   logic           access;
   logic           rd_status;
   logic           rd_ustatus;
   logic           wr_hit;

   assign rx_code    = rx_msg_in[14:9];
   assign framed     = ~rx_msg_in[15] & ~rx_msg_in[8] & (rx_msg_in[7:0] == `BFE_FRAME_ONES);
   assign validated  = rx_msg_valid_in & filter_ok_in;
   assign access     = (read_in | write_in) & (bus_state == BFE_BUS_DONE);
   assign rd_status  = access & read_in & (address_in == `BFE_IDX_STATUS);
   assign rd_ustatus = access & read_in & (address_in == `BFE_IDX_USTATUS);
   assign wr_hit     = access & write_in;

   // ***********************************************
   // Event detection
   // ***********************************************
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_match
         localparam int BITPOS = (gi == 0) ? `BFE_BIT_MATCH1 : (gi == 1) ? `BFE_BIT_MATCH2 : `BFE_BIT_MATCH3;
         assign set_bits[BITPOS] = validated & (rx_code == match_code[gi]);
      end
   endgenerate

   assign set_bits[`BFE_BIT_CLEARED] = rx_msg_valid_in & framed & ~rx_code_valid_in
                                       & (noncode_run == 2'h2);
   assign set_bits[`BFE_BIT_ABORT]   = rx_bit_en_in & rx_bit_in & (ones_run == 4'h8);
   assign set_bits[`BFE_BIT_FULL]    = rx_msg_valid_in;
   assign set_bits[`BFE_BIT_EMPTIED] = tx_rep_done_in & ((tx_count + 8'h01) >= repeat_count);
   assign set_bits[`BFE_BIT_CHANGE]  = validated & code_seen & (rx_code != last_code);

   // Run of framed messages without a valid code; saturates at the limit
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         noncode_run <= 2'h0;
      end else if (rx_msg_valid_in) begin
         if (framed & ~rx_code_valid_in) begin
            if (noncode_run != `BFE_NONCODE_RUN) begin
               noncode_run <= noncode_run + 2'h1;
            end
         end else begin
            noncode_run <= 2'h0;
         end
      end
   end

   // Run of ones on the link bits
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ones_run <= 4'h0;
      end else if (rx_bit_en_in) begin
         if (!rx_bit_in) begin
            ones_run <= 4'h0;
         end else if (ones_run != `BFE_ABORT_RUN) begin
            ones_run <= ones_run + 4'h1;
         end
      end
   end

   // Repetitions of the transmit message
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tx_count <= 8'h00;
      end else if (tx_load_in) begin
         tx_count <= 8'h00;
      end else if (tx_rep_done_in) begin
         tx_count <= set_bits[`BFE_BIT_EMPTIED] ? 8'h00 : tx_count + 8'h01;
      end
   end

   // Last validated code
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         last_code <= `BFE_RST_CODE;
         code_seen <= 1'b0;
      end else if (validated) begin
         last_code <= rx_code;
         code_seen <= 1'b1;
      end
   end

   // Last valid sync message
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         last_ssm <= `BFE_RST_CODE;
         ssm_seen <= 1'b0;
      end else if (ssm_valid_in) begin
         last_ssm <= ssm_in;
         ssm_seen <= 1'b1;
      end
   end

   // ***********************************************
   // Sticky flags; a new event wins over the read clear
   // ***********************************************
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         status <= `BFE_RST_BYTE;
      end else begin
         status <= (status & ~(rd_status ? readdata_out[7:0] : 8'h00)) | set_bits;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ustatus <= 1'b0;
      end else begin
         ustatus <= (ustatus & ~(rd_ustatus & readdata_out[`BFE_BIT_UNSTABLE]))
                    | (ssm_valid_in & ssm_seen & (ssm_in != last_ssm));
      end
   end

   // ***********************************************
   // Software registers
   // ***********************************************
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         enable        <= `BFE_RST_BYTE;
         uenable       <= 1'b0;
         match_code[0] <= `BFE_RST_CODE;
         match_code[1] <= `BFE_RST_CODE;
         match_code[2] <= `BFE_RST_CODE;
         repeat_count  <= `BFE_RST_REPEAT;
      end else if (wr_hit) begin
         case (address_in)
            `BFE_IDX_ENABLE:  enable        <= writedata_in[7:0];
            `BFE_IDX_UENABLE: uenable       <= writedata_in[`BFE_BIT_UNSTABLE];
            `BFE_IDX_MATCH1:  match_code[0] <= writedata_in[5:0];
            `BFE_IDX_MATCH2:  match_code[1] <= writedata_in[5:0];
            `BFE_IDX_MATCH3:  match_code[2] <= writedata_in[5:0];
            `BFE_IDX_REPEAT:  repeat_count  <= writedata_in[7:0];
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      case (address_in)
         `BFE_IDX_STATUS:  rd_value = status;
         `BFE_IDX_ENABLE:  rd_value = enable;
         `BFE_IDX_USTATUS: rd_value = {1'b0, ustatus, 6'h00};
         `BFE_IDX_UENABLE: rd_value = {1'b0, uenable, 6'h00};
         `BFE_IDX_MATCH1:  rd_value = {2'h0, match_code[0]};
         `BFE_IDX_MATCH2:  rd_value = {2'h0, match_code[1]};
         `BFE_IDX_MATCH3:  rd_value = {2'h0, match_code[2]};
         `BFE_IDX_REPEAT:  rd_value = repeat_count;
         default:          rd_value = 8'h00;
      endcase
   end

   // ***********************************************
   // Bus slave: data captured first, taken next edge
   // ***********************************************
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bus_state       <= BFE_BUS_IDLE;
         waitrequest_out <= 1'b1;
         readdata_out    <= 32'h0000_0000;
      end else begin
         case (bus_state)
            BFE_BUS_IDLE: begin
               if (read_in | write_in) begin
                  bus_state       <= BFE_BUS_DONE;
                  waitrequest_out <= 1'b0;
                  readdata_out    <= read_in ? {24'h00_0000, rd_value} : 32'h0000_0000;
               end
            end
            BFE_BUS_DONE: begin
               bus_state       <= BFE_BUS_IDLE;
               waitrequest_out <= 1'b1;
            end
            default: begin
               bus_state       <= BFE_BUS_IDLE;
               waitrequest_out <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= (|(status & enable)) | (ustatus & uenable);
      end
   end

   // ***********************************************
   // Checks
   // ***********************************************
   property p_match3;
      @(posedge clock_in) disable iff (!rst_n_in)
      validated && rx_code == match_code[2] |=> status[`BFE_BIT_MATCH3];
   endproperty
   a_match3: assert property (p_match3) else $error("match three not flagged");

   property p_match2;
      @(posedge clock_in) disable iff (!rst_n_in)
      validated && rx_code == match_code[1] |=> status[`BFE_BIT_MATCH2];
   endproperty
   a_match2: assert property (p_match2) else $error("match two not flagged");

   property p_match1;
      @(posedge clock_in) disable iff (!rst_n_in)
      rx_msg_valid_in && !filter_ok_in && !status[`BFE_BIT_MATCH1] |=> !status[`BFE_BIT_MATCH1];
   endproperty
   a_match1: assert property (p_match1) else $error("match one set without filter");

   property p_cleared;
      @(posedge clock_in) disable iff (!rst_n_in)
      rx_msg_valid_in && framed && !rx_code_valid_in && noncode_run == 2'h2 |=> status[`BFE_BIT_CLEARED];
   endproperty
   a_cleared: assert property (p_cleared) else $error("code cleared not flagged");

   property p_abort;
      @(posedge clock_in) disable iff (!rst_n_in)
      rx_bit_en_in && rx_bit_in && ones_run == 4'h8 |=> status[`BFE_BIT_ABORT];
   endproperty
   a_abort: assert property (p_abort) else $error("abort not flagged");

   property p_full;
      @(posedge clock_in) disable iff (!rst_n_in)
      rx_msg_valid_in |=> status[`BFE_BIT_FULL];
   endproperty
   a_full: assert property (p_full) else $error("full not flagged");

   property p_emptied;
      @(posedge clock_in) disable iff (!rst_n_in)
      tx_rep_done_in && !tx_load_in && tx_count + 8'h01 == repeat_count |=> status[2] && tx_count == 8'h00;
   endproperty
   a_emptied: assert property (p_emptied) else $error("emptied not flagged");

   property p_change;
      @(posedge clock_in) disable iff (!rst_n_in)
      validated && code_seen && rx_code != last_code |=> status[`BFE_BIT_CHANGE];
   endproperty
   a_change: assert property (p_change) else $error("change not flagged");

   property p_unstable;
      @(posedge clock_in) disable iff (!rst_n_in)
      ssm_valid_in && !ssm_seen && !ustatus |=> !ustatus;
   endproperty
   a_unstable: assert property (p_unstable) else $error("unstable set before valid message");

   property p_rdclear;
      @(posedge clock_in) disable iff (!rst_n_in)
      rd_status && set_bits == 8'h00 |=> (status & $past(readdata_out[7:0])) == 8'h00;
   endproperty
   a_rdclear: assert property (p_rdclear) else $error("status not cleared by read");

   property p_resv;
      @(posedge clock_in) disable iff (!rst_n_in)
      bus_state == BFE_BUS_DONE && read_in && address_in == `BFE_IDX_USTATUS |-> readdata_out[7] == 1'b0
      && readdata_out[5:0] == 6'h00;
   endproperty
   a_resv: assert property (p_resv) else $error("reserved bits not zero");

   property p_uresv;
      @(posedge clock_in) disable iff (!rst_n_in)
      bus_state == BFE_BUS_DONE && read_in && address_in == `BFE_IDX_UENABLE |-> readdata_out[7] == 1'b0
      && readdata_out[5:0] == 6'h00;
   endproperty
   a_uresv: assert property (p_uresv) else $error("unstable enable reserved bits not zero");

   property p_gate;
      @(posedge clock_in) disable iff (!rst_n_in)
      status[`BFE_BIT_CLEARED] && !enable[`BFE_BIT_CLEARED] && (status & enable) == 8'h00 && !ustatus |=> !irq_out;
   endproperty
   a_gate: assert property (p_gate) else $error("code cleared interrupt while disabled");

   property p_irq;
      @(posedge clock_in) disable iff (!rst_n_in)
      ##1 irq_out == ($past(|(status & enable)) || $past(ustatus & uenable));
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt level wrong");

   property p_bus;
      @(posedge clock_in) disable iff (!rst_n_in)
      (read_in || write_in) && waitrequest_out |=> !waitrequest_out ##1 waitrequest_out;
   endproperty
   a_bus: assert property (p_bus) else $error("bus answer timing wrong");

endmodule : bfe_event_irq

// ---- core/bfe_cfg.svh ----
// Offsets, field positions, reset values and counts of the code event block
`ifndef BFE_CFG_SVH
`define BFE_CFG_SVH
// Register indices; byte address is four times the index
`define BFE_IDX_STATUS    8'h70
`define BFE_IDX_ENABLE    8'h71
`define BFE_IDX_USTATUS   8'h74
`define BFE_IDX_UENABLE   8'h75
`define BFE_IDX_MATCH1    8'h60
`define BFE_IDX_MATCH2    8'h61
`define BFE_IDX_MATCH3    8'h62
`define BFE_IDX_REPEAT    8'h63
// Status and enable bit positions
`define BFE_BIT_MATCH3    7
`define BFE_BIT_MATCH2    6
`define BFE_BIT_CLEARED   5
`define BFE_BIT_ABORT     4
`define BFE_BIT_FULL      3
`define BFE_BIT_EMPTIED   2
`define BFE_BIT_MATCH1    1
`define BFE_BIT_CHANGE    0
`define BFE_BIT_UNSTABLE  6
// Reset values
`define BFE_RST_BYTE      8'h00
`define BFE_RST_CODE      6'h00
`define BFE_RST_REPEAT    8'h01
// Message framing and counts
`define BFE_FRAME_ONES    8'hff
`define BFE_NONCODE_RUN   2'h3
`define BFE_ABORT_RUN     4'h9
`endif

// ---- core/bfe_pkg.sv ----
// Types shared by the code event block
package bfe_pkg;
   typedef enum logic [1:0] {
      BFE_BUS_IDLE = 2'b00,
      BFE_BUS_DONE = 2'b01
   } bfe_bus_state_t;
endpackage : bfe_pkg

// ---- verif/bfe_far_end.sv ----
// Remote terminal model feeding link messages, link bits, repeats and sync status
`timescale 1ns/10ps
module bfe_far_end (
   input  wire logic        clock_in,
   output logic      [15:0] rx_msg_out,
   output logic             rx_msg_valid_out,
   output logic             rx_code_valid_out,
   output logic             filter_ok_out,
   output logic             rx_bit_out,
   output logic             rx_bit_en_out,
   output logic             tx_load_out,
   output logic             tx_rep_done_out,
   output logic      [5:0]  ssm_out,
   output logic             ssm_valid_out
);
   initial begin
      rx_msg_out = 16'h0000;
      rx_msg_valid_out = 1'b0;
      rx_code_valid_out = 1'b0;
      filter_ok_out = 1'b0;
      rx_bit_out = 1'b0;
      rx_bit_en_out = 1'b0;
      tx_load_out = 1'b0;
      tx_rep_done_out = 1'b0;
      ssm_out = 6'h00;
      ssm_valid_out = 1'b0;
   end

   // Framed message; qualifiers and data inverted once the pulse is over
   task automatic send_msg(input logic [5:0] code, input logic code_ok, input logic filt);
      @(posedge clock_in);
      rx_msg_out <= {1'b0, code, 1'b0, 8'hff};
      rx_msg_valid_out <= 1'b1;
      rx_code_valid_out <= code_ok;
      filter_ok_out <= filt;
      @(posedge clock_in);
      rx_msg_out <= ~{1'b0, code, 1'b0, 8'hff};
      rx_msg_valid_out <= 1'b0;
      rx_code_valid_out <= ~code_ok;
      filter_ok_out <= ~filt;
   endtask : send_msg

   // A run of ones closed by one zero
   task automatic send_run(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clock_in);
         rx_bit_out <= 1'b1;
         rx_bit_en_out <= 1'b1;
      end
      @(posedge clock_in);
      rx_bit_out <= 1'b0;
      @(posedge clock_in);
      rx_bit_en_out <= 1'b0;
      rx_bit_out <= 1'b1;
   endtask : send_run

   task automatic send_reps(input int n, input logic load);
      if (load) begin
         @(posedge clock_in);
         tx_load_out <= 1'b1;
      end
      for (int i = 0; i < n; i++) begin
         @(posedge clock_in);
         tx_load_out <= 1'b0;
         tx_rep_done_out <= 1'b1;
      end
      @(posedge clock_in);
      tx_load_out <= 1'b0;
      tx_rep_done_out <= 1'b0;
   endtask : send_reps

   task automatic send_ssm(input logic [5:0] v);
      @(posedge clock_in);
      ssm_out <= v;
      ssm_valid_out <= 1'b1;
      @(posedge clock_in);
      ssm_out <= ~v;
      ssm_valid_out <= 1'b0;
   endtask : send_ssm
endmodule : bfe_far_end

// ---- verif/tb_bfe_event_irq.sv ----
// Self-checking bench of the code event and interrupt block
`timescale 1ns/10ps
`include "bfe_cfg.svh"
module tb_bfe_event_irq;
   logic        clock_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic [7:0]  address_in = 8'h00;
   logic        read_in = 1'b0;
   logic        write_in = 1'b0;
   logic [31:0] writedata_in = 32'h0;
   logic [31:0] readdata_out;
   logic        waitrequest_out, irq_out, msg_v, code_v, filt, rbit, rbit_en, tx_ld, tx_dn, ssm_v;
   logic [15:0] msg;
   logic [5:0]  ssm;
   int          error_cnt = 0;
   int          compares = 0;

   always #2 clock_in = ~clock_in;

   bfe_event_irq dut_u (.clock_in(clock_in), .rst_n_in(rst_n_in), .address_in(address_in),
      .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in), .readdata_out(readdata_out),
      .waitrequest_out(waitrequest_out), .rx_msg_in(msg), .rx_msg_valid_in(msg_v),
      .rx_code_valid_in(code_v), .filter_ok_in(filt), .rx_bit_in(rbit), .rx_bit_en_in(rbit_en),
      .tx_load_in(tx_ld), .tx_rep_done_in(tx_dn), .ssm_in(ssm), .ssm_valid_in(ssm_v), .irq_out(irq_out));

   bfe_far_end far_u (.clock_in(clock_in), .rx_msg_out(msg), .rx_msg_valid_out(msg_v),
      .rx_code_valid_out(code_v), .filter_ok_out(filt), .rx_bit_out(rbit), .rx_bit_en_out(rbit_en),
      .tx_load_out(tx_ld), .tx_rep_done_out(tx_dn), .ssm_out(ssm), .ssm_valid_out(ssm_v));

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // Request held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge clock_in);
      read_in <= !wr;
      write_in <= wr;
      address_in <= a;
      writedata_in <= {24'h0, d};
      do @(posedge clock_in); while (waitrequest_out !== 1'b0);
      q = readdata_out[7:0];
      read_in <= 1'b0;
      write_in <= 1'b0;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(nm, q, exp);
   endtask : rd

   task automatic irq_is(input logic exp);
      repeat (3) @(posedge clock_in);
      chk("irq", {7'h0, irq_out}, {7'h0, exp});
   endtask : irq_is

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_regs;
      rd("status", `BFE_IDX_STATUS, 8'h00);
      rd("enable", `BFE_IDX_ENABLE, 8'h00);
      rd("ustatus", `BFE_IDX_USTATUS, 8'h00);
      rd("uenable", `BFE_IDX_UENABLE, 8'h00);
      rd("unmapped", 8'h7f, 8'h00);
      rd("repeat", `BFE_IDX_REPEAT, 8'h01);
      wr(`BFE_IDX_ENABLE, 8'hff);
      rd("enable", `BFE_IDX_ENABLE, 8'hff);
      wr(`BFE_IDX_UENABLE, 8'hff);
      rd("uenable", `BFE_IDX_UENABLE, 8'h40);
      wr(`BFE_IDX_STATUS, 8'hff);
      rd("status", `BFE_IDX_STATUS, 8'h00);
      wr(`BFE_IDX_UENABLE, 8'h00);
      wr(`BFE_IDX_ENABLE, 8'h08);
      $display("test regs done");
   endtask : t_regs

   task automatic t_full;
      far_u.send_msg(6'h00, 1'b0, 1'b0);
      irq_is(1'b1);
      rd("status", `BFE_IDX_STATUS, 8'h08);
      rd("status", `BFE_IDX_STATUS, 8'h00);
      irq_is(1'b0);
      $display("test full done");
   endtask : t_full

   task automatic t_match;
      wr(`BFE_IDX_MATCH1, 8'h05);
      wr(`BFE_IDX_MATCH2, 8'h0a);
      wr(`BFE_IDX_MATCH3, 8'h15);
      far_u.send_msg(6'h05, 1'b1, 1'b1);
      rd("status", `BFE_IDX_STATUS, 8'h0a);
      far_u.send_msg(6'h0a, 1'b1, 1'b1);
      rd("status", `BFE_IDX_STATUS, 8'h49);
      far_u.send_msg(6'h15, 1'b1, 1'b1);
      rd("status", `BFE_IDX_STATUS, 8'h89);
      far_u.send_msg(6'h05, 1'b1, 1'b0);
      rd("status", `BFE_IDX_STATUS, 8'h08);
      $display("test match done");
   endtask : t_match

   task automatic t_clear;
      wr(`BFE_IDX_ENABLE, 8'h20);
      repeat (2) far_u.send_msg(6'h00, 1'b0, 1'b0);
      irq_is(1'b0);
      rd("status", `BFE_IDX_STATUS, 8'h08);
      wr(`BFE_IDX_ENABLE, 8'h00);
      far_u.send_msg(6'h00, 1'b0, 1'b0);
      irq_is(1'b0);
      wr(`BFE_IDX_ENABLE, 8'h20);
      irq_is(1'b1);
      rd("status", `BFE_IDX_STATUS, 8'h28);
      $display("test clear done");
   endtask : t_clear

   task automatic t_abort;
      wr(`BFE_IDX_ENABLE, 8'h10);
      far_u.send_run(8);
      rd("status", `BFE_IDX_STATUS, 8'h00);
      far_u.send_run(9);
      irq_is(1'b1);
      rd("status", `BFE_IDX_STATUS, 8'h10);
      $display("test abort done");
   endtask : t_abort

   task automatic t_empty;
      far_u.send_reps(1, 1'b1);
      rd("status", `BFE_IDX_STATUS, 8'h04);
      wr(`BFE_IDX_REPEAT, 8'h03);
      far_u.send_reps(2, 1'b1);
      rd("status", `BFE_IDX_STATUS, 8'h00);
      far_u.send_reps(1, 1'b0);
      rd("status", `BFE_IDX_STATUS, 8'h04);
      far_u.send_reps(1, 1'b0);
      rd("status", `BFE_IDX_STATUS, 8'h00);
      $display("test empty done");
   endtask : t_empty

   task automatic t_unstable;
      wr(`BFE_IDX_ENABLE, 8'h00);
      wr(`BFE_IDX_UENABLE, 8'h40);
      repeat (2) far_u.send_ssm(6'h11);
      rd("ustatus", `BFE_IDX_USTATUS, 8'h00);
      far_u.send_ssm(6'h12);
      irq_is(1'b1);
      rd("ustatus", `BFE_IDX_USTATUS, 8'h40);
      rd("ustatus", `BFE_IDX_USTATUS, 8'h00);
      irq_is(1'b0);
      $display("test unstable done");
   endtask : t_unstable

   // ****************************************
   // Sequence, watchdog and verdict
   // ****************************************
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (10) @(posedge clock_in);
      rst_n_in <= 1'b1;
      t_regs();
      t_full();
      t_match();
      t_clear();
      t_abort();
      t_empty();
      t_unstable();
      tally_and_finish();
   end

   initial begin
      repeat (5000) @(posedge clock_in);
      error_cnt++;
      tally_and_finish();
   end
endmodule : tb_bfe_event_irq
